// *** acc_top.sv ***
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module acc_top
	import acc_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// analog side, levels
	input wire logic POSITIVE_INPUT_PIN_I,
	input wire logic NEGATIVE_INPUT_PIN_I,
	input wire logic BANDGAP_I,
	input wire logic [ACC_NUM_CHAN-1:0] ANALOG_CHANNEL_PINS_I,
	output logic COMPARATOR_POWER_OFF_O,
	output logic NEGATIVE_FROM_MUX_O,
	// processor side
	input wire logic VECTOR_ACK_I,
	output logic COMPARATOR_IRQ_O,
	// timer capture side
	output logic CAPTURE_INPUT_O,
	output logic CAPTURE_EVENT_O,
	// summary interrupt
	output logic IRQ_O
);
	typedef struct packed {
		logic power_off;
		logic bandgap_sel;
		logic irq_flag;
		logic irq_en;
		logic capture_en;
		logic [1:0] mode;
		logic mux_en;
		logic conv_en;
		logic [ACC_CHAN_W-1:0] chan;
		logic global_en;
		logic [ACC_IRQ_W-1:0] irq_status;
		logic [ACC_IRQ_W-1:0] irq_mask;
		logic [31:0] rdata;
		logic cap_in;
		logic cap_ev;
	} acc_state_t;

	acc_state_t st_q, st_d;
	logic raw;
	logic neg_mux;
	logic sync;
	logic rise;
	logic fall;
	logic event_hit;
	logic wr;
	logic rd;
	logic rd_setup;
	logic [7:0] ctrl_view;
	acc_mode_t mode;

	acc_input_sel u_sel (
		.bandgap_sel_i(st_q.bandgap_sel),
		.mux_en_i(st_q.mux_en),
		.conv_en_i(st_q.conv_en),
		.chan_i(st_q.chan),
		.pos_pin_i(POSITIVE_INPUT_PIN_I),
		.neg_pin_i(NEGATIVE_INPUT_PIN_I),
		.bandgap_i(BANDGAP_I),
		.chan_pins_i(ANALOG_CHANNEL_PINS_I),
		.power_off_i(st_q.power_off),
		.raw_o(raw),
		.neg_from_mux_o(neg_mux)
	);

	acc_sync_edge u_sync (
		.clk_i(CLOCK_I),
		.rst_n_i(RST_N_I),
		.raw_i(raw),
		.sync_o(sync),
		.rise_o(rise),
		.fall_o(fall)
	);

	assign mode = acc_mode_t'(st_q.mode);
	always_comb begin
		case (mode)
			ACC_MODE_TOGGLE: event_hit = rise || fall;
			ACC_MODE_FALL: event_hit = fall;
			ACC_MODE_RISE: event_hit = rise;
			// reserved code never triggers
			default: event_hit = 1'b0;
		endcase
	end

	assign wr = PSEL_I && PENABLE_I && PWRITE_I;
	assign rd = PSEL_I && PENABLE_I && !PWRITE_I;
	assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;

	always_comb begin
		ctrl_view = ACC_RST_CTRL;
		ctrl_view[ACC_BIT_POWER_OFF] = st_q.power_off;
		ctrl_view[ACC_BIT_BANDGAP] = st_q.bandgap_sel;
		ctrl_view[ACC_BIT_RESULT] = sync;
		ctrl_view[ACC_BIT_IRQ_FLAG] = st_q.irq_flag;
		ctrl_view[ACC_BIT_IRQ_EN] = st_q.irq_en;
		ctrl_view[ACC_BIT_CAPTURE] = st_q.capture_en;
		ctrl_view[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO] = st_q.mode;
	end

	always_comb begin
		st_d = st_q;
		st_d.rdata = 32'h0000_0000;
		// clears first so a same-cycle event still sets
		if (VECTOR_ACK_I) begin
			st_d.irq_flag = 1'b0;
		end
		// clear only what the snapshot showed, so an event between setup and access survives
		if (rd && PADDR_I == ACC_OFF_IRQ_STATUS) begin
			st_d.irq_status = st_q.irq_status & ~st_q.rdata[ACC_IRQ_W-1:0];
		end
		if (wr) begin
			case (PADDR_I)
				ACC_OFF_CTRL_STATUS: begin
					st_d.power_off = PWDATA_I[ACC_BIT_POWER_OFF];
					st_d.bandgap_sel = PWDATA_I[ACC_BIT_BANDGAP];
					if (PWDATA_I[ACC_BIT_IRQ_FLAG]) begin
						st_d.irq_flag = 1'b0;
					end
					st_d.irq_en = PWDATA_I[ACC_BIT_IRQ_EN];
					st_d.capture_en = PWDATA_I[ACC_BIT_CAPTURE];
					st_d.mode = PWDATA_I[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO];
				end
				ACC_OFF_SPECIAL_IO: st_d.mux_en = PWDATA_I[ACC_BIT_MUX_EN];
				ACC_OFF_CONV_INPUT: st_d.chan = PWDATA_I[ACC_CHAN_W-1:0];
				ACC_OFF_CONV_CTRL: st_d.conv_en = PWDATA_I[ACC_BIT_CONV_EN];
				ACC_OFF_IRQ_MASK: st_d.irq_mask = PWDATA_I[ACC_IRQ_W-1:0];
				ACC_OFF_GLOBAL: st_d.global_en = PWDATA_I[0];
				default: st_d.global_en = st_q.global_en;
			endcase
		end
		// snapshot taken in the setup cycle, held through the access cycle
		if (rd_setup) begin
			case (PADDR_I)
				ACC_OFF_CTRL_STATUS: st_d.rdata = {24'h000000, ctrl_view};
				ACC_OFF_SPECIAL_IO: st_d.rdata = {28'h0000000, st_q.mux_en, 3'h0};
				ACC_OFF_CONV_INPUT: st_d.rdata = {29'h00000000, st_q.chan};
				ACC_OFF_CONV_CTRL: st_d.rdata = {24'h000000, st_q.conv_en, 7'h00};
				ACC_OFF_IRQ_STATUS: st_d.rdata = {30'h00000000, st_q.irq_status};
				ACC_OFF_IRQ_MASK: st_d.rdata = {30'h00000000, st_q.irq_mask};
				ACC_OFF_GLOBAL: st_d.rdata = {31'h00000000, st_q.global_en};
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end
		// hardware set wins over any clear in the same cycle
		if (event_hit) begin
			st_d.irq_flag = 1'b1;
			st_d.irq_status[ACC_IRQ_CMP_EVENT] = 1'b1;
		end
		// capture path only exists while routed
		st_d.cap_in = st_q.capture_en && sync;
		st_d.cap_ev = st_q.capture_en && (rise || fall);
		if (st_q.capture_en && (rise || fall)) begin
			st_d.irq_status[ACC_IRQ_CAPTURE] = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// read data leaves straight from flops with no wait state;
	// the price is a view one cycle older than the access edge
	assign PRDATA_O = st_q.rdata;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !(PADDR_I == ACC_OFF_CTRL_STATUS ||
		PADDR_I == ACC_OFF_SPECIAL_IO || PADDR_I == ACC_OFF_CONV_INPUT ||
		PADDR_I == ACC_OFF_CONV_CTRL || PADDR_I == ACC_OFF_IRQ_STATUS ||
		PADDR_I == ACC_OFF_IRQ_MASK || PADDR_I == ACC_OFF_GLOBAL);

	assign COMPARATOR_POWER_OFF_O = st_q.power_off;
	assign NEGATIVE_FROM_MUX_O = neg_mux;
	assign COMPARATOR_IRQ_O = st_q.irq_flag && st_q.irq_en && st_q.global_en;
	assign CAPTURE_INPUT_O = st_q.cap_in;
	assign CAPTURE_EVENT_O = st_q.cap_ev;
	assign IRQ_O = |(st_q.irq_status & st_q.irq_mask);
endmodule // acc_top

// *** acc_pkg.sv ***
package acc_pkg;
	// apb register byte offsets
	localparam logic [7:0] ACC_OFF_CTRL_STATUS = 8'h08;
	localparam logic [7:0] ACC_OFF_SPECIAL_IO = 8'h0c;
	localparam logic [7:0] ACC_OFF_CONV_INPUT = 8'h10;
	localparam logic [7:0] ACC_OFF_CONV_CTRL = 8'h14;
	localparam logic [7:0] ACC_OFF_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ACC_OFF_IRQ_MASK = 8'h1c;
	localparam logic [7:0] ACC_OFF_GLOBAL = 8'h20;
	// comparator_control_status field positions
	localparam int ACC_BIT_POWER_OFF = 7;
	localparam int ACC_BIT_BANDGAP = 6;
	localparam int ACC_BIT_RESULT = 5;
	localparam int ACC_BIT_IRQ_FLAG = 4;
	localparam int ACC_BIT_IRQ_EN = 3;
	localparam int ACC_BIT_CAPTURE = 2;
	localparam int ACC_BIT_MODE_HI = 1;
	localparam int ACC_BIT_MODE_LO = 0;
	// special_function_io / converter fields
	localparam int ACC_BIT_MUX_EN = 3;
	localparam int ACC_BIT_CONV_EN = 7;
	localparam int ACC_CHAN_W = 3;
	localparam int ACC_NUM_CHAN = 8;
	// interrupt status bits
	localparam int ACC_IRQ_W = 2;
	localparam int ACC_IRQ_CMP_EVENT = 0;
	localparam int ACC_IRQ_CAPTURE = 1;
	// reset values
	localparam logic [7:0] ACC_RST_CTRL = 8'h00;
	localparam logic [7:0] ACC_RST_BYTE = 8'h00;
	localparam logic [1:0] ACC_RST_IRQ = 2'h0;
	// interrupt mode codes
	typedef enum logic [1:0] {
		ACC_MODE_TOGGLE = 2'h0,
		ACC_MODE_RESERVED = 2'h1,
		ACC_MODE_FALL = 2'h2,
		ACC_MODE_RISE = 2'h3
	} acc_mode_t;
endpackage

// *** acc_input_sel.sv ***
`timescale 1ns/1ns
module acc_input_sel
	import acc_pkg::*;
(
	// selects
	input wire logic bandgap_sel_i,
	input wire logic mux_en_i,
	input wire logic conv_en_i,
	input wire logic [ACC_CHAN_W-1:0] chan_i,
	// analog levels as digital view, and the power-off control
	input wire logic pos_pin_i,
	input wire logic neg_pin_i,
	input wire logic bandgap_i,
	input wire logic [ACC_NUM_CHAN-1:0] chan_pins_i,
	input wire logic power_off_i,
	// raw result and negative-input mux flag
	output logic raw_o,
	output logic neg_from_mux_o
);
	logic pos;
	logic neg;
	always_comb begin
		pos = bandgap_sel_i ? bandgap_i : pos_pin_i;
		neg_from_mux_o = mux_en_i && !conv_en_i;
		neg = neg_from_mux_o ? chan_pins_i[chan_i] : neg_pin_i;
		// inputs modelled as 1-bit levels: positive above negative
		raw_o = !power_off_i && pos && !neg;
	end
endmodule // acc_input_sel

// *** acc_sync_edge.sv ***
`timescale 1ns/1ns
module acc_sync_edge (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic raw_i,
	output logic sync_o,
	output logic rise_o,
	output logic fall_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
	} acc_sync_t;
	acc_sync_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.s1 = raw_i;
		st_d.s2 = st_q.s1;
		st_d.prev = st_q.s2;
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign sync_o = st_q.s2;
	assign rise_o = st_q.s2 && !st_q.prev;
	assign fall_o = !st_q.s2 && st_q.prev;
endmodule // acc_sync_edge

// *** acc_assertions.sv ***
`timescale 1ns/1ns
module acc_checker (
	// watched ports
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic COMPARATOR_POWER_OFF_O,
	input wire logic NEGATIVE_FROM_MUX_O,
	input wire logic COMPARATOR_IRQ_O,
	input wire logic CAPTURE_INPUT_O,
	input wire logic CAPTURE_EVENT_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	wire acc = PSEL_I && PENABLE_I;
	wire wr08 = acc && PWRITE_I && PADDR_I == 8'h08;
	wire rd08 = acc && !PWRITE_I && PADDR_I == 8'h08;
	a_power_write: assert property (wr08 |=> COMPARATOR_POWER_OFF_O == $past(PWDATA_I[7]))
		else $error("power-off bit missed its write");
	a_power_hold: assert property (!wr08 |=> $stable(COMPARATOR_POWER_OFF_O))
		else $error("power-off bit moved without a write");
	a_off_quiet: assert property (COMPARATOR_POWER_OFF_O [*4] |-> !CAPTURE_INPUT_O)
		else $error("result high while powered off");
	a_event_change: assert property (CAPTURE_EVENT_O |-> CAPTURE_INPUT_O != $past(CAPTURE_INPUT_O))
		else $error("capture event without a result change");
	a_route_off: assert property (rd08 && !PRDATA_O[2] |-> !CAPTURE_INPUT_O && !CAPTURE_EVENT_O)
		else $error("capture path active while unrouted");
	// read data is the setup-cycle snapshot, so compare with the request of that cycle
	a_irq_cause: assert property (rd08 && $past(COMPARATOR_IRQ_O) |-> PRDATA_O[4] && PRDATA_O[3])
		else $error("interrupt without flag and enable");
	a_irq_global: assert property (acc && !PWRITE_I && PADDR_I == 8'h20 && !PRDATA_O[0] |-> !COMPARATOR_IRQ_O)
		else $error("interrupt while global enable low");
	a_mux_off: assert property (acc && !PWRITE_I && PADDR_I == 8'h0c && !PRDATA_O[3] |-> !NEGATIVE_FROM_MUX_O)
		else $error("channel mux used while disabled");
endmodule // acc_checker
bind acc_top acc_checker u_chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.COMPARATOR_POWER_OFF_O(COMPARATOR_POWER_OFF_O), .NEGATIVE_FROM_MUX_O(NEGATIVE_FROM_MUX_O),
	.COMPARATOR_IRQ_O(COMPARATOR_IRQ_O), .CAPTURE_INPUT_O(CAPTURE_INPUT_O), .CAPTURE_EVENT_O(CAPTURE_EVENT_O));

// *** acc_far_side.sv ***
`timescale 1ns/1ns
module acc_far_side (
	// clock and requested levels
	input wire logic clk_i,
	input wire logic [10:0] level_i,
	// timer capture side
	input wire logic cap_event_i,
	input wire logic cap_irq_en_i,
	output logic cap_irq_o,
	output int n_cap_o,
	// analog levels
	output logic [10:0] pins_o
);
	logic [10:0] pins = 11'h000;
	int n_cap = 0;
	// levels move just after an edge, like a real source
	always @(posedge clk_i) begin
		pins <= level_i;
		if (cap_event_i) n_cap <= n_cap + 1;
	end
	assign pins_o = pins;
	assign n_cap_o = n_cap;
	assign cap_irq_o = cap_event_i && cap_irq_en_i;
endmodule // acc_far_side

// *** test_acc_top.sv ***
`timescale 1ns/1ns
module test_acc_top;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pw = 0, vack = 0, ready, err, pwr, mux, cirq, cin, cev, irq;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0, prd, rd;
	logic [10:0] level = 11'h000, pins;
	logic [18:0] r;
	int n_errors = 0, checks = 0, n_cap;
	// bgsel mux conv chan3 pos neg bg chanpins8 expect_result expect_mux
	localparam logic [18:0] ROWS [8] = '{19'b0_0_0_000_100_00000000_1_0, 19'b0_0_0_000_110_00000000_0_0,
		19'b1_0_0_000_001_00000000_1_0, 19'b1_0_0_000_100_00000000_0_0, 19'b0_1_0_101_110_11011111_1_1,
		19'b0_1_0_010_100_00000100_0_1, 19'b0_1_1_010_100_11111111_1_0, 19'b0_1_0_111_110_01111111_1_1};
	always #50 clk = ~clk;
	acc_far_side u_far (.clk_i(clk), .level_i(level), .cap_event_i(cev), .cap_irq_en_i(1'b1), .cap_irq_o(),
		.n_cap_o(n_cap), .pins_o(pins));
	acc_top dut (.CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw), .PADDR_I(addr),
		.PWDATA_I(wd), .PRDATA_O(prd), .PREADY_O(ready), .PSLVERR_O(err), .POSITIVE_INPUT_PIN_I(pins[10]),
		.NEGATIVE_INPUT_PIN_I(pins[9]), .BANDGAP_I(pins[8]), .ANALOG_CHANNEL_PINS_I(pins[7:0]),
		.COMPARATOR_POWER_OFF_O(pwr), .NEGATIVE_FROM_MUX_O(mux), .VECTOR_ACK_I(vack), .COMPARATOR_IRQ_O(cirq),
		.CAPTURE_INPUT_O(cin), .CAPTURE_EVENT_O(cev), .IRQ_O(irq));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pw <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (ready !== 1'b1);
		rd = {prd[31:1], prd[0] | err};
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic settle;
		repeat (5) @(posedge clk);
	endtask
	task automatic complete_run;
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ROWS[i]) begin
			r = ROWS[i];
			level <= r[12:2];
			apb(1, 8'h08, {25'h0, r[18], 6'h00});
			apb(1, 8'h0c, {28'h0, r[17], 3'h0});
			apb(1, 8'h10, {29'h0, r[15:13]});
			apb(1, 8'h14, {24'h0, r[16], 7'h00});
			settle;
			apb(0, 8'h08, 32'h0);
			chk("result", rd[5], r[1]);
			chk("neg_mux", mux, r[0]);
		end
		apb(1, 8'h0c, 32'h0);
		apb(0, 8'h0c, 32'h0);
		chk("mux_rd", {mux, rd[3]}, 2'h0);
		for (int m = 0; m < 4; m++) begin
			level <= 11'h200;
			apb(1, 8'h08, 32'h10 | m);
			settle;
			apb(1, 8'h08, 32'h10 | m);
			level <= 11'h400;
			settle;
			apb(0, 8'h08, 32'h0);
			chk("flag_rise", rd[4], m == 0 || m == 3);
			apb(1, 8'h08, 32'h10 | m);
			level <= 11'h200;
			settle;
			apb(0, 8'h08, 32'h0);
			chk("flag_fall", rd[4], m == 0 || m == 2);
		end
		apb(1, 8'h08, 32'h10);
		apb(1, 8'h20, 32'h1);
		apb(1, 8'h1c, 32'h1);
		apb(1, 8'h08, 32'h08);
		level <= 11'h400;
		settle;
		chk("irq_on", {irq, cirq}, 2'h3);
		apb(1, 8'h08, 32'h08);
		chk("irq_keep", cirq, 1'b1);
		apb(0, 8'h08, 32'h0);
		chk("irq_bits", rd[4:3], 2'h3);
		apb(0, 8'h18, 32'h0);
		chk("status", {irq, rd[1:0]}, 3'h1);
		vack <= 1'b1;
		@(posedge clk);
		vack <= 1'b0;
		@(posedge clk);
		chk("irq_ack", cirq, 1'b0);
		apb(1, 8'h20, 32'h0);
		apb(0, 8'h20, 32'h0);
		chk("global_rd", {cirq, rd[0]}, 2'h0);
		level <= 11'h200;
		settle;
		apb(0, 8'h08, 32'h0);
		chk("irq_global", {cirq, rd[4]}, 2'h1);
		apb(1, 8'h08, 32'h14);
		apb(0, 8'h08, 32'h0);
		chk("flag_clr", rd[4], 1'b0);
		level <= 11'h400;
		settle;
		chk("cap_input", cin, 1'b1);
		level <= 11'h200;
		settle;
		@(posedge clk);
		chk("cap_count", n_cap, 2);
		apb(0, 8'h18, 32'h0);
		chk("cap_status", rd[1:0], 2'h3);
		apb(1, 8'h08, 32'h80);
		level <= 11'h400;
		settle;
		apb(0, 8'h08, 32'h0);
		chk("power_off", {pwr, rd[7:5]}, 4'hc);
		apb(0, 8'h04, 32'h0);
		chk("unmapped", rd, 32'h1);
		complete_run;
	end
	initial begin
		#1000000;
		n_errors++;
		complete_run;
	end
endmodule // test_acc_top
